// file: hw/fpp_pkg.sv
package fpp_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 4;
    localparam int          WORDS         = 256;
    localparam int          MAX_TRIES     = 4;
    localparam logic [2:0]  TRY_RST       = 3'h0;
    localparam logic [7:0]  ADDR_RST      = 8'h00;
    localparam logic [3:0]  DATA_RST      = 4'hF;
    localparam int          CLK_PERIOD_NS = 25;
    // Programming pulse width and settling times, in ns
    localparam int          PULSE_NS      = 180000;
    localparam int          SETUP_NS      = 1000;
    localparam int          VERIFY_NS     = 1000;
    localparam int          PULSE_CYC     = PULSE_NS / CLK_PERIOD_NS;
    localparam int          SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
    localparam int          VERIFY_CYC    = (VERIFY_NS + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
    localparam int          CNT_W         = 16;
    typedef enum logic [1:0] {
        FPP_OP_READ,
        FPP_OP_PROG
    } fpp_op_t;
endpackage

// file: hw/fpp_sync.sv
`timescale 1ns/1ps
module fpp_sync
    import fpp_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_ce,
    input  wire logic [DATA_W-1:0] i_async,
    output logic      [DATA_W-1:0] o_sync
);
    logic [DATA_W-1:0] meta_q;
    logic [DATA_W-1:0] sync_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            meta_q <= DATA_RST;
            sync_q <= DATA_RST;
        end else if (i_ce) begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// file: hw/fpp_host.sv
`timescale 1ns/1ps
module fpp_host
    import fpp_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC
)
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_ce,
    input  wire logic              i_start,
    input  wire logic              i_op,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [DATA_W-1:0] i_prom_data,
    output logic      [ADDR_W-1:0] o_prom_addr,
    output logic                   o_prom_en1_n,
    output logic                   o_prom_en2_n,
    output logic      [DATA_W-1:0] o_prog_pulse,
    output logic                   o_verify_supply_level,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_busy,
    output logic                   o_done,
    output logic                   o_fail
);
    typedef enum logic [2:0] {
        S_IDLE, S_SEL, S_PULSE, S_EN, S_CHECK, S_READ
    } fpp_state_t;

    fpp_state_t         state_q;
    logic [CNT_W-1:0]   cnt_q;
    logic [2:0]         tries_q;
    logic [1:0]         bit_q;
    logic [DATA_W-1:0]  todo_q;
    logic [DATA_W-1:0]  data_s;

    fpp_sync u_sync (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_async   (i_prom_data),
        .o_sync    (data_s)
    );

    function automatic logic [1:0] first_set(input logic [DATA_W-1:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int k = DATA_W - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = 2'(k);
            end
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] onehot(input logic [1:0] b);
        return DATA_W'(1) << b;
    endfunction

    // Sequencer
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_q <= S_IDLE;
            cnt_q   <= '0;
            tries_q <= TRY_RST;
            bit_q   <= 2'h0;
            todo_q  <= '0;
        end else if (i_ce) begin
            case (state_q)
                S_IDLE: begin
                    cnt_q <= '0;
                    if (i_start && i_op) begin
                        todo_q  <= ~i_wdata;
                        bit_q   <= first_set(~i_wdata);
                        tries_q <= TRY_RST;
                        state_q <= (i_wdata == DATA_RST) ? S_IDLE : S_SEL;
                    end else if (i_start) begin
                        state_q <= S_READ;
                    end
                end
                S_READ: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(VERIFY_CYC + 2)) begin
                        state_q <= S_IDLE;
                    end
                end
                S_SEL: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(SETUP_CYC)) begin
                        cnt_q   <= '0;
                        state_q <= S_PULSE;
                    end
                end
                S_PULSE: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(PULSE_CYCLES - 1)) begin
                        cnt_q   <= '0;
                        tries_q <= tries_q + 1'b1;
                        state_q <= S_EN;
                    end
                end
                S_EN: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(VERIFY_CYC + 2)) begin
                        cnt_q   <= '0;
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (!data_s[bit_q]) begin
                        todo_q[bit_q] <= 1'b0;
                        tries_q <= TRY_RST;
                        bit_q   <= first_set(todo_q & ~onehot(bit_q));
                        state_q <= ((todo_q & ~onehot(bit_q)) == '0)
                                   ? S_IDLE : S_SEL;
                    end else if (tries_q == 3'(MAX_TRIES)) begin
                        state_q <= S_IDLE;
                    end else begin
                        state_q <= S_SEL;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Pin drive
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_prom_addr           <= ADDR_RST;
            o_prom_en1_n          <= 1'b1;
            o_prom_en2_n          <= 1'b1;
            o_prog_pulse          <= '0;
            o_verify_supply_level <= 1'b0;
        end else if (i_ce) begin
            o_prog_pulse <= '0;
            case (state_q)
                S_IDLE: begin
                    o_prom_en1_n          <= 1'b1;
                    o_prom_en2_n          <= 1'b1;
                    o_verify_supply_level <= 1'b0;
                    if (i_start) begin
                        o_prom_addr <= i_addr;
                    end
                end
                S_READ: begin
                    o_prom_en1_n <= 1'b0;
                    o_prom_en2_n <= 1'b0;
                end
                S_SEL: begin
                    o_prom_en1_n          <= 1'b1;
                    o_prom_en2_n          <= 1'b0;
                    o_verify_supply_level <= 1'b0;
                    if (cnt_q == CNT_W'(SETUP_CYC)) begin
                        o_prog_pulse <= onehot(bit_q);
                    end
                end
                S_PULSE: begin
                    if (cnt_q != CNT_W'(PULSE_CYCLES - 1)) begin
                        o_prog_pulse <= onehot(bit_q);
                    end
                end
                S_EN: begin
                    o_prom_en1_n          <= 1'b0;
                    o_prom_en2_n          <= 1'b0;
                    o_verify_supply_level <= 1'b1;
                end
                S_CHECK: begin
                    o_verify_supply_level <= 1'b1;
                end
                default: o_prog_pulse <= '0;
            endcase
        end
    end

    // Status and read data
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rdata <= DATA_RST;
            o_busy  <= 1'b0;
            o_done  <= 1'b0;
            o_fail  <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            o_busy <= (state_q != S_IDLE) || i_start;
            if (state_q == S_IDLE && i_start) begin
                o_fail <= 1'b0;
                if (i_op && i_wdata == DATA_RST) begin
                    o_done <= 1'b1;
                end
            end
            if (state_q == S_READ && cnt_q == CNT_W'(VERIFY_CYC + 2)) begin
                o_rdata <= data_s;
                o_done  <= 1'b1;
            end
            if (state_q == S_CHECK) begin
                o_rdata <= data_s;
                if (!data_s[bit_q] &&
                    (todo_q & ~onehot(bit_q)) == '0) begin
                    o_done <= 1'b1;
                end else if (data_s[bit_q] &&
                             tries_q == 3'(MAX_TRIES)) begin
                    o_done <= 1'b1;
                    o_fail <= 1'b1;
                end
            end
        end
    end
endmodule

// file: verification/fpp_prom_model.sv
`timescale 1ns/1ps
module fpp_prom_model #(
    parameter bit THREE_ST = 1'b1
)
(
    input  wire logic [7:0] i_addr,
    input  wire logic       i_en1_n,
    input  wire logic       i_en2_n,
    input  wire logic [3:0] i_pulse,
    input  wire logic       i_stuck,
    output logic      [3:0] o_data,
    output int              o_pulses
);
    logic [3:0] mem [256];
    initial begin
        o_pulses = 0;
        foreach (mem[i]) mem[i] = 4'hF;
    end
    always @(i_pulse) begin
        if ($onehot(i_pulse) && (i_en1_n || i_en2_n)) begin
            o_pulses++;
            if (!i_stuck) mem[i_addr] &= ~i_pulse;
        end
    end
    assign o_data = (!i_en1_n && !i_en2_n) ? mem[i_addr]
                  : (THREE_ST ? 4'hZ : 4'hF);
endmodule

// file: verification/fpp_host_sva.sv
`timescale 1ns/1ps
module fpp_host_sva
    import fpp_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC
)
(
    input wire logic              i_ref_clk,
    input wire logic              i_sys_rst,
    input wire logic              i_ce,
    input wire logic              i_start,
    input wire logic              i_op,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic [DATA_W-1:0] i_prom_data,
    input wire logic [ADDR_W-1:0] o_prom_addr,
    input wire logic              o_prom_en1_n,
    input wire logic              o_prom_en2_n,
    input wire logic [DATA_W-1:0] o_prog_pulse,
    input wire logic              o_verify_supply_level,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              o_busy,
    input wire logic              o_done,
    input wire logic              o_fail
);
    logic [CNT_W-1:0] hi_cnt_q;

    // Counts enabled cycles with a pulse line high
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || !(|o_prog_pulse)) begin
            hi_cnt_q <= '0;
        end else if (i_ce) begin
            hi_cnt_q <= hi_cnt_q + 1'b1;
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    pulse_width_a: assert property ($fell(|o_prog_pulse) |->
        hi_cnt_q == CNT_W'(PULSE_CYCLES)) else $error("pulse width off");
    pulse_onehot_a: assert property ($onehot0(o_prog_pulse))
        else $error("more than one pulse line active");
    pulse_disabled_a: assert property (|o_prog_pulse |->
        o_prom_en1_n || o_prom_en2_n) else $error("pulse while enabled");
    pre_pulse_a: assert property ($rose(|o_prog_pulse) |->
        $past(o_prom_en1_n || o_prom_en2_n) && $stable(o_prom_addr))
        else $error("pulse without prior select");
    pulse_stable_a: assert property (|o_prog_pulse &&
        $past(|o_prog_pulse) |-> $stable(o_prom_addr) &&
        $stable(o_prom_en1_n) && $stable(o_prom_en2_n))
        else $error("pins moved during pulse");
    verify_en_a: assert property (o_verify_supply_level |->
        !o_prom_en1_n && !o_prom_en2_n) else $error("verify while off");
    after_pulse_a: assert property ($fell(|o_prog_pulse) |=>
        o_verify_supply_level && !o_prom_en1_n && !o_prom_en2_n)
        else $error("no verify after pulse");
    addr_take_a: assert property (i_ce && i_start && !o_busy &&
        (!i_op || i_wdata != 4'hF) |=> o_prom_addr == $past(i_addr))
        else $error("address not presented");
    fail_done_a: assert property ($rose(o_fail) |-> o_done)
        else $error("fail without done");
    read_time_a: assert property (i_ce && i_start && !o_busy &&
        !i_op |-> ##44 o_done) else $error("read not finished");
    cover property ($rose(o_fail));
    cover property ($rose(|o_prog_pulse));
    cover property (o_done && !o_fail);
endmodule
bind fpp_host fpp_host_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (.*);

// file: verification/fpp_host_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module fpp_host_test;
    import fpp_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       start = 1'b0;
    logic       op = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [3:0] wdata = 4'hF;
    logic       stuck = 1'b0;
    logic       ce = 1'b1;
    logic [7:0] lfsr_q = 8'h0E;
    logic [3:0] expm [256];
    tri1  [3:0] bus;
    logic [7:0] paddr;
    logic [3:0] pulse, rdata;
    logic       en1_n, en2_n, vlev, busy, done, fail;
    int         error_cnt = 0, n_tests = 0, cyc = 0, pulses, p0;
    fpp_host #(.PULSE_CYCLES(8)) DUT (.i_ref_clk(clk), .i_sys_rst(rst),
        .i_ce(ce), .i_start(start), .i_op(op), .i_addr(addr),
        .i_wdata(wdata), .i_prom_data(bus), .o_prom_addr(paddr),
        .o_prom_en1_n(en1_n), .o_prom_en2_n(en2_n), .o_prog_pulse(pulse),
        .o_verify_supply_level(vlev), .o_rdata(rdata), .o_busy(busy),
        .o_done(done), .o_fail(fail));
    fpp_prom_model u_prom (.i_addr(paddr), .i_en1_n(en1_n),
        .i_en2_n(en2_n), .i_pulse(pulse), .i_stuck(stuck), .o_data(bus),
        .o_pulses(pulses));
    initial forever #12.5 clk = ~clk;
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [3:0] blown(input logic [3:0] old,
                                         input logic [3:0] w);
        return old & w;
    endfunction
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic run(input logic o, input logic [7:0] a,
                       input logic [3:0] w);
        @(negedge clk);
        start = 1'b1; op = o; addr = a; wdata = w;
        @(negedge clk);
        start = 1'b0;
        for (int k = 0; k < 3000 && done !== 1'b1; k++) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        run(1'b0, a, 4'hF);
        `CHK(rdata, expm[a])
    endtask
    task automatic prog(input logic [7:0] a, input logic [3:0] w);
        run(1'b1, a, w);
        expm[a] = blown(expm[a], w);
        `CHK(fail, 1'b0)
        rd(a);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        foreach (expm[i]) expm[i] = 4'hF;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(8'h00);
        rd(8'hFF);
        prog(8'hFF, 4'h0);
        prog(8'h00, 4'hA);
        prog(8'h00, 4'h5);
        prog(8'h10, 4'hF);
        repeat (6) begin
            lfsr_q = lfsr_next(lfsr_q);
            prog(lfsr_q, lfsr_q[7:4]);
        end
        fork
            prog(8'h44, 4'h7);
            begin
                p0 = pulses;
                repeat (6) @(negedge clk);
                ce = 1'b0;
                repeat (40) @(negedge clk);
                `CHK(pulses - p0, 0)
                ce = 1'b1;
            end
        join
        stuck = 1'b1;
        p0 = pulses;
        run(1'b1, 8'h33, 4'hE);
        `CHK(fail, 1'b1)
        `CHK(pulses - p0, 4)
        stuck = 1'b0;
        rd(8'h33);
        final_report();
    end
endmodule
